// >>> mcf_field_model.sv
`timescale 1ns/100ps
module mcf_field_model
    import mcf_pkg::*;
#(
    parameter int NBEAMS = 16
)(
    input  wire logic               clk,        // system clock
    input  wire logic               slow,       // one extra cycle of lag
    input  wire logic [SENSORS-1:0] want_sens,  // requested sensor levels
    input  wire logic [NBEAMS-1:0]  want_beam,  // requested blocked beams
    output logic      [SENSORS-1:0] sens,       // sensor pin levels
    output logic      [NBEAMS-1:0]  beam        // beam interruption levels
);
    // ---------------------------------------------------------------
    // goods and sensors
    // ---------------------------------------------------------------
    logic [SENSORS-1:0] sens_q;
    logic [NBEAMS-1:0]  beam_q;

    // objects move on the clock, a slow belt arrives one cycle later
    always_ff @(posedge clk)
    begin
        sens_q <= want_sens;
        beam_q <= want_beam;
        sens   <= slow ? sens_q : want_sens;
        beam   <= slow ? beam_q : want_beam;
    end
endmodule : mcf_field_model

// >>> mcf_gap_delay.sv
`timescale 1ns/100ps
module mcf_gap_delay
    import mcf_pkg::*;
#(
    parameter int DELAY = GAP_CYC
)(
    input  wire logic               clk,     // system clock
    input  wire logic               rst,     // sync reset, high
    input  wire logic               enable,  // gap suppression on
    input  wire logic [SENSORS-1:0] din,     // synced sensor levels
    output logic      [SENSORS-1:0] dout     // delayed sensor levels
);

    localparam int CW = $clog2(DELAY + 1);

    if (DELAY < 1)
    begin : g_bad_delay
        $error("mcf_gap_delay: DELAY must be at least 1");
    end

    logic [CW-1:0] cnt [SENSORS];

    // -----------------------------------------------------------------
    // per sensor: with enable set, a level is passed on only once held for DELAY cycles
    // -----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < SENSORS; i++)
        begin
            if (rst)
            begin
                cnt[i]  <= '0;
                dout[i] <= 1'b0;
            end
            else if (!enable)
            begin
                cnt[i]  <= '0;
                dout[i] <= din[i];
            end
            else if (din[i] != dout[i])
            begin
                if (cnt[i] == CW'(DELAY - 1))
                begin
                    cnt[i]  <= '0;
                    dout[i] <= din[i];
                end
                else
                begin
                    cnt[i] <= cnt[i] + CW'(1);
                end
            end
            else
            begin
                cnt[i] <= '0;                        // short dropout forgotten
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_gap_release: assert property (
        enable && $past(enable) && din[0] != dout[0] && cnt[0] == CW'(DELAY - 1)
        |=> dout[0] == $past(din[0]))
        else $error("delayed sensor not released after full delay");

    a_gap_hold: assert property (
        enable && din[1] != dout[1] && cnt[1] != CW'(DELAY - 1)
        |=> dout[1] == $past(dout[1]))
        else $error("delayed sensor changed before delay ran out");

    a_no_delay: assert property (
        !enable |=> dout == $past(din))
        else $error("sensor delayed while gap suppression off");

endmodule : mcf_gap_delay

// >>> mcf_pkg.sv
package mcf_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TEACH   = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_RANGE   = 8'h0C;
    localparam logic [7:0] ADDR_DISPLAY = 8'h10;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_W          = 9;    // option bits [8:0] of ctrl
    localparam int TEACH_START_BIT = 0;
    localparam int TEACH_END_BIT   = 1;
    localparam int STAT_MUTE_BIT   = 0;
    localparam int STAT_TEACH_BIT  = 1;
    localparam int STAT_VIOL_BIT   = 2;
    localparam int STAT_SENS_LSB   = 4;    // delayed sensors [7:4]
    localparam int RANGE_HI_LSB    = 16;   // lo in [15:0], hi in [31:16]

    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic [8:0] CTRL_RST  = 9'h000;
    localparam int         CLK_MHZ   = 200;
    localparam int         GAP_MS    = 250;
    localparam int         GAP_CYC   = GAP_MS * 1000 * CLK_MHZ;  // longest, exact
    localparam int         SENSORS   = 4;
    localparam int         NBEAMS_DF = 32;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic full_mute_en;     // [8]
        logic belt_stop_en;     // [7]
        logic mute_enable_in;   // [6]
        logic two_linear;       // [5]
        logic cross_mute;       // [4]
        logic four_linear;      // [3]
        logic gap_suppress;     // [2]
        logic partial_en;       // [1]
        logic field_clear_end;  // [0]
    } mcf_ctrl_t;

    typedef struct packed {
        logic       teach_prefix;   // shown while teaching
        logic [3:0] hundreds;
        logic [3:0] tens;
        logic [3:0] ones;
    } mcf_disp_t;

endpackage : mcf_pkg

// >>> mcf_top.sv
`timescale 1ns/100ps
module mcf_top
    import mcf_pkg::*;
#(
    parameter int NBEAMS    = NBEAMS_DF,
    parameter int GAP_DELAY = GAP_CYC
)(
    input  wire logic               clk,                 // 200 MHz clock
    input  wire logic               rst,                 // sync reset, high
    input  wire logic               psel,                // apb select
    input  wire logic               penable,             // apb access phase
    input  wire logic               pwrite,              // apb direction
    input  wire logic [7:0]         paddr,               // apb byte address
    input  wire logic [31:0]        pwdata,              // apb write data
    output logic      [31:0]        prdata,              // apb read data
    output logic                    pready,              // apb ready
    output logic                    pslverr,             // apb error
    input  wire logic [SENSORS-1:0] muting_sensor_input, // sensor pins
    input  wire logic [NBEAMS-1:0]  beam_blocked,        // beam interrupted
    input  wire logic               mute_start,          // sequence began, pulse
    input  wire logic               mute_seq_done,       // sequence/timer done
    output logic      [SENSORS-1:0] muting_sensor_eval,  // sensors after delay
    output logic                    mute_active,         // muting in force
    output logic      [NBEAMS-1:0]  beam_muted,          // per-beam mute
    output logic                    field_violation,     // unmuted beam blocked
    output mcf_ctrl_t               mode_cfg,            // active options
    output mcf_disp_t               blocked_beam_count_display // teach display
);

    localparam int IW = $clog2(NBEAMS);
    localparam int CW = $clog2(NBEAMS + 1);

    if (NBEAMS < 2 || NBEAMS > 999)
    begin : g_bad_nbeams
        $error("mcf_top: NBEAMS out of 2..999");
    end

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [CW-1:0] count_ones(input logic [NBEAMS-1:0] v);
        logic [CW-1:0] c;
        c = '0;
        for (int i = 0; i < NBEAMS; i++) c = c + CW'(v[i]);
        return c;
    endfunction : count_ones

    function automatic logic [IW-1:0] lowest(input logic [NBEAMS-1:0] v);
        logic [IW-1:0] r;
        r = '0;
        for (int i = NBEAMS - 1; i >= 0; i--) if (v[i]) r = IW'(i);
        return r;
    endfunction : lowest

    function automatic logic [IW-1:0] highest(input logic [NBEAMS-1:0] v);
        logic [IW-1:0] r;
        r = '0;
        for (int i = 0; i < NBEAMS; i++) if (v[i]) r = IW'(i);
        return r;
    endfunction : highest

    function automatic mcf_disp_t to_disp(input logic pre, input logic [CW-1:0] c);
        mcf_disp_t d;
        int        n;
        n          = int'(c);
        d.teach_prefix = pre;
        d.hundreds = 4'(n / 100);
        d.tens     = 4'((n / 10) % 10);
        d.ones     = 4'(n % 10);
        return d;
    endfunction : to_disp

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [SENSORS-1:0] sens_m, sens_s;
    logic [NBEAMS-1:0]  beam_m, beam_s;

    always_ff @(posedge clk)
    begin
        sens_m <= rst ? '0 : muting_sensor_input;
        sens_s <= rst ? '0 : sens_m;
        beam_m <= rst ? '0 : beam_blocked;
        beam_s <= rst ? '0 : beam_m;
    end

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    mcf_ctrl_t       ctrl;
    logic            teaching;
    logic [IW-1:0]   range_lo, range_hi;
    logic            seen_blocked;   // field was blocked during this mute

    mcf_gap_delay #(.DELAY(GAP_DELAY)) u_gap (
        .clk    (clk),
        .rst    (rst),
        .enable (ctrl.gap_suppress),
        .din    (sens_s),
        .dout   (muting_sensor_eval)
    );

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    wire apb_acc   = psel && penable && pready;
    wire apb_wr    = apb_acc && pwrite;
    wire hit_ctrl  = paddr == ADDR_CTRL;
    wire hit_teach = paddr == ADDR_TEACH;
    wire mapped    = hit_ctrl || hit_teach || paddr == ADDR_STATUS
                   || paddr == ADDR_RANGE || paddr == ADDR_DISPLAY;

    // a ctrl write replaces every option; 4-linear forces bits [8:4] off
    wire mcf_ctrl_t wr_ctrl = mcf_ctrl_t'(pwdata[CTRL_W-1:0]);
    wire mcf_ctrl_t next_ctrl = wr_ctrl.four_linear
                              ? mcf_ctrl_t'(wr_ctrl & 9'h00F) : wr_ctrl;

    wire teach_go  = apb_wr && hit_teach && pwdata[TEACH_START_BIT];
    wire teach_end = apb_wr && hit_teach && pwdata[TEACH_END_BIT] && teaching;

    // -----------------------------------------------------------------
    // teach arithmetic on the live beam snapshot
    // -----------------------------------------------------------------
    wire [CW-1:0] blk_count = count_ones(beam_s);
    wire [IW-1:0] blk_lo    = lowest(beam_s);
    wire [IW-1:0] blk_hi    = highest(beam_s);
    wire [IW-1:0] next_lo   = (blk_lo == '0) ? '0 : blk_lo - IW'(1);
    wire [IW-1:0] next_hi   = (blk_hi == IW'(NBEAMS - 1))
                            ? blk_hi : blk_hi + IW'(1);

    // -----------------------------------------------------------------
    // mute decisions
    // -----------------------------------------------------------------
    wire field_clear = ~|beam_s;
    wire end_by_field = ctrl.field_clear_end && seen_blocked && field_clear;
    wire next_mute = mute_start ? 1'b1
                   : (end_by_field || mute_seq_done) ? 1'b0 : mute_active;

    logic [NBEAMS-1:0] in_range;
    always_comb
    begin
        for (int i = 0; i < NBEAMS; i++)
            in_range[i] = (IW'(i) >= range_lo) && (IW'(i) <= range_hi);
    end

    wire [NBEAMS-1:0] next_muted = {NBEAMS{next_mute}}
                                 & (ctrl.partial_en ? in_range : '1);

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl     <= mcf_ctrl_t'(CTRL_RST);
            teaching <= 1'b0;
            range_lo <= '0;
            range_hi <= IW'(NBEAMS - 1);
        end
        else
        begin
            if (apb_wr && hit_ctrl) ctrl <= next_ctrl;
            teaching <= teach_go ? 1'b1 : teach_end ? 1'b0 : teaching;
            if (teach_end && blk_count != '0)
            begin
                range_lo <= next_lo;
                range_hi <= next_hi;
            end
        end
    end

    // muting state and its outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mute_active     <= 1'b0;
            seen_blocked    <= 1'b0;
            beam_muted      <= '0;
            field_violation <= 1'b0;
        end
        else
        begin
            mute_active     <= next_mute;
            seen_blocked    <= next_mute && (seen_blocked || !field_clear);
            beam_muted      <= next_muted;
            field_violation <= |(beam_s & ~next_muted);
        end
    end

    // display and mirrored options
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            blocked_beam_count_display <= '0;
            mode_cfg                   <= mcf_ctrl_t'(CTRL_RST);
        end
        else
        begin
            blocked_beam_count_display <= teaching ? to_disp(1'b1, blk_count) : '0;
            mode_cfg                   <= (apb_wr && hit_ctrl) ? next_ctrl : ctrl;
        end
    end

    // apb slave: one wait cycle, error on unmapped address
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= '0;
            if (psel && penable && !pready && !pwrite)
            begin
                case (paddr)
                    ADDR_CTRL:    prdata <= 32'(ctrl);
                    ADDR_TEACH:   prdata <= 32'(teaching);
                    ADDR_STATUS:  prdata <= 32'({muting_sensor_eval, 1'b0, field_violation,
                                                 teaching, mute_active});
                    ADDR_RANGE:   prdata <= (32'(range_hi) << RANGE_HI_LSB) | 32'(range_lo);
                    ADDR_DISPLAY: prdata <= 32'(blocked_beam_count_display);
                    default:      prdata <= '0;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_commit_blocked;
        teach_end && blk_count != '0;
    endsequence

    sequence s_apb_access;
        psel && !penable ##1 psel && penable;
    endsequence

    a_field_clear_end: assert property (
        end_by_field && !mute_start |=> !mute_active)
        else $error("muting kept after field cleared");

    a_mute_holds: assert property (
        mute_active && !ctrl.field_clear_end && !mute_seq_done |=> mute_active)
        else $error("muting ended before sequence done");

    a_partial_mask: assert property (
        $past(ctrl.partial_en) && $stable(range_lo) && $stable(range_hi)
        |-> (beam_muted & ~in_range) == '0)
        else $error("beam outside taught span muted");

    a_teach_display: assert property (
        teaching ##1 teaching |-> blocked_beam_count_display.teach_prefix
        && blocked_beam_count_display.ones == 4'(int'($past(blk_count)) % 10))
        else $error("teach display wrong");

    a_widen_span: assert property (
        s_commit_blocked ##0 (blk_lo != '0) |=> range_lo == $past(blk_lo) - IW'(1))
        else $error("taught span not widened");

    a_empty_teach: assert property (
        teach_end && blk_count == '0 |=> $stable(range_lo) && $stable(range_hi))
        else $error("empty teach changed span");

    a_mode_exclusive: assert property (
        ctrl.four_linear |-> !(ctrl.cross_mute || ctrl.two_linear
        || ctrl.mute_enable_in || ctrl.belt_stop_en || ctrl.full_mute_en))
        else $error("other muting mode left on");

    a_span_order: assert property (
        s_commit_blocked |=> range_lo <= range_hi)
        else $error("taught span reversed");

    a_apb_ready: assert property (
        s_apb_access |=> pready)
        else $error("apb answer late");

endmodule : mcf_top

// >>> muting_option_control_bench.sv
`timescale 1ns/100ps
module muting_option_control_bench;
    import mcf_pkg::*;
    localparam int NB = 16;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata;
    logic               pready, pslverr, field_violation, mute_active;
    logic               mute_start = 1'b0, mute_seq_done = 1'b0, slow = 1'b0;
    logic [SENSORS-1:0] want_sens = 4'h0, sens, eval;
    logic [NB-1:0]      want_beam = 16'h0, beam, beam_muted;
    mcf_ctrl_t          mode_cfg;
    mcf_disp_t          disp;
    int                 num_errors = 0, cmp_count = 0, cycles = 0;

    // clock at 200 MHz
    always #2.5 clk = ~clk;

    mcf_field_model #(.NBEAMS(NB)) field_u (.clk(clk), .slow(slow),
        .want_sens(want_sens), .want_beam(want_beam), .sens(sens), .beam(beam));

    mcf_top #(.NBEAMS(NB), .GAP_DELAY(8)) dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .muting_sensor_input(sens), .beam_blocked(beam), .mute_start(mute_start),
        .mute_seq_done(mute_seq_done), .muting_sensor_eval(eval),
        .mute_active(mute_active), .beam_muted(beam_muted),
        .field_violation(field_violation), .mode_cfg(mode_cfg),
        .blocked_beam_count_display(disp));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic give_verdict;
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer, held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
    endtask : rd_chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task automatic field(input logic [3:0] s, input logic [NB-1:0] b);
        @(posedge clk);
        want_sens <= s;
        want_beam <= b;
    endtask : field

    // one-cycle pulse on the start or end strobe
    task automatic mute_evt(input logic endit);
        @(posedge clk);
        if (endit)
            mute_seq_done <= 1'b1;
        else
            mute_start <= 1'b1;
        @(posedge clk);
        mute_start    <= 1'b0;
        mute_seq_done <= 1'b0;
    endtask : mute_evt

    // ---------------------------------------------------------------
    // hang guard
    // ---------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        logic [31:0] q;
        logic        e;
        wait_cyc(6);
        rst <= 1'b0;
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("range", ADDR_RANGE, 32'h000F_0000);
        apb(1'b0, 8'h14, 32'h0, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        wr(ADDR_CTRL, 32'h0000_01FF);
        rd_chk("ctrl", ADDR_CTRL, 32'h0000_000F);
        wait_cyc(2);
        chk("mode_cfg", 32'h0000_000F, {23'h0, mode_cfg});
        // sensors with and without gap suppression
        wr(ADDR_CTRL, 32'h0);
        field(4'hA, 16'h0);
        wait_cyc(6);
        chk("eval", 32'hA, {28'h0, eval});
        wr(ADDR_CTRL, 32'h4);
        field(4'h5, 16'h0);
        wait_cyc(6);
        chk("eval", 32'hA, {28'h0, eval});
        wait_cyc(14);
        chk("eval", 32'h5, {28'h0, eval});
        field(4'h0, 16'h0);
        wait_cyc(4);
        field(4'h5, 16'h0);
        wait_cyc(20);
        chk("eval", 32'h5, {28'h0, eval});
        // end of muting by sequence only, then by field clearing
        for (int fc = 0; fc < 2; fc++)
        begin
            wr(ADDR_CTRL, fc);
            field(4'h0, 16'h0010);
            wait_cyc(4);
            mute_evt(1'b0);
            wait_cyc(3);
            chk("mute_active", 32'h1, {31'h0, mute_active});
            chk("beam_muted", 32'hFFFF, {16'h0, beam_muted});
            field(4'h0, 16'h0);
            wait_cyc(8);
            if (fc == 0)
                chk("mute_active", 32'h1, {31'h0, mute_active});
            else
                chk("mute_active", 32'h0, {31'h0, mute_active});
            mute_evt(1'b1);
            wait_cyc(1);
            chk("mute_active", 32'h0, {31'h0, mute_active});
        end
        // teach a twelve-beam object, then an empty teach
        field(4'h0, 16'h3FFC);
        wr(ADDR_TEACH, 32'h1);
        wait_cyc(6);
        chk("display", 32'h1012, {19'h0, disp});
        rd_chk("display reg", ADDR_DISPLAY, 32'h0000_1012);
        rd_chk("teach", ADDR_TEACH, 32'h1);
        wr(ADDR_TEACH, 32'h2);
        rd_chk("range", ADDR_RANGE, 32'h000E_0001);
        chk("display", 32'h0, {19'h0, disp});
        field(4'h0, 16'h0);
        wr(ADDR_TEACH, 32'h1);
        wait_cyc(4);
        chk("display", 32'h1000, {19'h0, disp});
        wr(ADDR_TEACH, 32'h2);
        rd_chk("range", ADDR_RANGE, 32'h000E_0001);
        // partial muting with a slow belt
        slow <= 1'b1;
        wr(ADDR_CTRL, 32'h2);
        field(4'h0, 16'h0020);
        wait_cyc(6);
        mute_evt(1'b0);
        wait_cyc(3);
        chk("beam_muted", 32'h7FFE, {16'h0, beam_muted});
        chk("violation", 32'h0, {31'h0, field_violation});
        field(4'h0, 16'h0021);
        wait_cyc(6);
        chk("violation", 32'h1, {31'h0, field_violation});
        rd_chk("status", ADDR_STATUS, 32'h0000_0005);
        mute_evt(1'b1);
        give_verdict();
    end
endmodule : muting_option_control_bench
